// ===== core/htr_cur_pkg.sv
package htr_cur_pkg;
  // ---------------------------------------------------------------------------
  // Setpoint coding
  // ---------------------------------------------------------------------------
  // Setpoints and currents are in 0.5 A steps; code 0 means off.
  localparam int SP_W = 8;
  localparam logic [7:0] SP_OFF = 8'h00;
  localparam logic [7:0] SP_MAX_30A = 8'h3C;
  localparam logic [7:0] SP_MAX_100A = 8'hC8;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam int CUR_W = 10;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_LO_SP = 8'h00;
  localparam logic [7:0] OFS_HI_SP = 8'h04;
  localparam logic [7:0] OFS_TRIP_SP = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_TRIP_CLR = 8'h1C;
  localparam logic [7:0] OFS_LIMIT_SP = 8'h20;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  // Low, high and trip setpoint words hold main, phase B, phase C in bytes 0, 1, 2; the limit word holds main in byte 0 only.
  localparam int POS_MAIN = 0;
  localparam int POS_B = 8;
  localparam int POS_C = 16;
  localparam int CTRL_PROP = 0;
  localparam int CTRL_MODEL100 = 1;
  // Flag word: low alarms 2:0, high alarms 5:3, trips 8:6, limit active 9.
  localparam int FLG_LO = 0;
  localparam int FLG_HI = 3;
  localparam int FLG_TRIP = 6;
  localparam int FLG_LIM = 9;
  localparam int NFLG = 10;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== core/cur_compare.sv
`timescale 1ns/1ps
module cur_compare (
  input wire logic [9:0] cur,
  input wire logic [7:0] lo_sp,
  input wire logic [7:0] hi_sp,
  input wire logic [7:0] trip_sp,
  input wire logic hi_en,
  output logic lo_hit,
  output logic hi_hit,
  output logic trip_hit
);
  always_comb begin
    lo_hit = (lo_sp != htr_cur_pkg::SP_OFF) && (cur <= {2'b00, lo_sp});
    hi_hit = hi_en && (hi_sp != htr_cur_pkg::SP_OFF) && (cur >= {2'b00, hi_sp});
    trip_hit = (trip_sp != htr_cur_pkg::SP_OFF) && (cur >= {2'b00, trip_sp});
  end
endmodule

// ===== core/heater_current_alarm_trip.sv
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Phase C low alarm when current at/below setpoint.
// - Phase C low alarm clears above setpoint.
// - Setpoints are off or 0.5 A steps.
// - Main high alarm when current at/above setpoint.
// - Main high alarm clears below; never latches.
// - High alarms suppressed below full duty while prop_en (scaling) is on.
// - Phase B/C high alarms set and clear.
// - Main trip opens heater, raises latched alarm.
// - Trips latch until operator reset command.
// - Phase B trip opens heater, latches alarm.
// - Phase C trip opens heater, latches alarm.
// - Scale currents to full-power equivalent first.
// - Off setpoint disables; all setpoints reset off.
// - Power limit caps average heater current.
// - Main low alarm set at/below, clears above.
module heater_current_alarm_trip (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sample_valid,
  input wire logic [7:0] cur_main,
  input wire logic [7:0] cur_b,
  input wire logic [7:0] cur_c,
  input wire logic [7:0] duty,
  output logic heater_on,
  output logic irq
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Clamp a setpoint byte to the legal range of the fitted model.
  function automatic logic [7:0] clamp_sp(input logic [7:0] v, input logic big);
    logic [7:0] mx;
    mx = big ? htr_cur_pkg::SP_MAX_100A : htr_cur_pkg::SP_MAX_30A;
    clamp_sp = (v > mx) ? mx : v;
  endfunction

  // Full-power equivalent of a current sampled at the given duty.
  // With a resistive load the average scales with duty, so divide by duty.
  function automatic logic [9:0] full_eq(input logic [7:0] c, input logic [7:0] d,
                                         input logic en);
    logic [15:0] num;
    logic [15:0] q;
    num = {c, 8'h00} - {8'h00, c};
    q = (d == 8'h00) ? 16'h0000 : num / {8'h00, d};
    if (!en) begin
      full_eq = {2'b00, c};
    end else if (q > 16'h03FF) begin
      full_eq = 10'h3FF;
    end else begin
      full_eq = q[9:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0] lo_sp_r, lo_sp_nxt;
  logic [31:0] hi_sp_r, hi_sp_nxt;
  logic [31:0] trip_sp_r, trip_sp_nxt;
  logic [31:0] lim_sp_r, lim_sp_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [9:0] stat_r, stat_nxt;
  logic [9:0] mask_r, mask_nxt;
  logic [9:0] flag_r, flag_nxt;
  logic [2:0] trip_r, trip_nxt;
  logic lim_r, lim_nxt;
  logic heater_on_r, heater_on_nxt;
  logic irq_r, irq_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [2:0] trip_cond_r, trip_cond_nxt;
  logic awready_r, wready_r, arready_r;

  // ---------------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------------
  logic [7:0] cur_in [3];
  logic [2:0] lo_hit, hi_hit, trip_hit;
  logic prop_en, hi_en;

  assign cur_in[0] = cur_main;
  assign cur_in[1] = cur_b;
  assign cur_in[2] = cur_c;
  assign prop_en = ctrl_r[htr_cur_pkg::CTRL_PROP] || (lim_sp_r[7:0] != htr_cur_pkg::SP_OFF);
  // High alarms give false readings at partial duty under scaling, so they are held off below full duty while prop_en is set.
  assign hi_en = !(prop_en && (duty != htr_cur_pkg::DUTY_FULL));

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      cur_compare u_cmp (
        .cur(full_eq(cur_in[g], duty, prop_en)),
        .lo_sp(lo_sp_r[8*g +: 8]),
        .hi_sp(hi_sp_r[8*g +: 8]),
        .trip_sp(trip_sp_r[8*g +: 8]),
        .hi_en(hi_en),
        .lo_hit(lo_hit[g]),
        .hi_hit(hi_hit[g]),
        .trip_hit(trip_hit[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave and alarm state
  // ---------------------------------------------------------------------------
  logic wr_do, rd_do;
  logic wr_hit;
  logic [31:0] wmask;
  logic [9:0] rd_clr;
  logic [9:0] events;

  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  assign rd_do = arvalid && !rvalid_r;

  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    lo_sp_nxt = lo_sp_r;
    hi_sp_nxt = hi_sp_r;
    trip_sp_nxt = trip_sp_r;
    lim_sp_nxt = lim_sp_r;
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    flag_nxt = flag_r;
    trip_nxt = trip_r;
    lim_nxt = lim_r;
    trip_cond_nxt = trip_cond_r;
    rd_clr = '0;
    wr_hit = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{w_strb_r[i]}};
    end
    if (awvalid && !aw_got_r) begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && !w_got_r) begin
      w_got_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (wr_do) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      case (aw_addr_r)
        htr_cur_pkg::OFS_LO_SP: lo_sp_nxt = (lo_sp_r & ~wmask) | (w_data_r & wmask);
        htr_cur_pkg::OFS_HI_SP: hi_sp_nxt = (hi_sp_r & ~wmask) | (w_data_r & wmask);
        htr_cur_pkg::OFS_TRIP_SP: trip_sp_nxt = (trip_sp_r & ~wmask) | (w_data_r & wmask);
        htr_cur_pkg::OFS_LIMIT_SP: lim_sp_nxt = (lim_sp_r & ~wmask) | (w_data_r & wmask);
        htr_cur_pkg::OFS_CTRL: ctrl_nxt = w_strb_r[0] ? w_data_r[1:0] : ctrl_r;
        htr_cur_pkg::OFS_IRQ_MASK: mask_nxt = w_strb_r[0] ? w_data_r[9:0] : mask_r;
        htr_cur_pkg::OFS_TRIP_CLR: begin
          // Operator reset of a selected trip; ignored while the last sample shows
          // the cause, since the current lines hold no valid value between samples.
          if (w_strb_r[0]) begin
            trip_nxt = trip_r & ~(w_data_r[2:0] & ~trip_cond_r);
          end
        end
        htr_cur_pkg::OFS_FLAGS, htr_cur_pkg::OFS_IRQ_STAT: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      bresp_nxt = wr_hit ? htr_cur_pkg::RESP_OKAY : htr_cur_pkg::RESP_SLVERR;
      for (int p = 0; p < 3; p++) begin
        lo_sp_nxt[8*p +: 8] = clamp_sp(lo_sp_nxt[8*p +: 8], ctrl_nxt[1]);
        hi_sp_nxt[8*p +: 8] = clamp_sp(hi_sp_nxt[8*p +: 8], ctrl_nxt[1]);
        trip_sp_nxt[8*p +: 8] = clamp_sp(trip_sp_nxt[8*p +: 8], ctrl_nxt[1]);
      end
      lo_sp_nxt[31:24] = 8'h00;
      hi_sp_nxt[31:24] = 8'h00;
      trip_sp_nxt[31:24] = 8'h00;
      lim_sp_nxt = {24'h00_0000, clamp_sp(lim_sp_nxt[7:0], ctrl_nxt[1])};
    end
    if (rd_do) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = htr_cur_pkg::RESP_OKAY;
      case (araddr)
        htr_cur_pkg::OFS_LO_SP: rdata_nxt = lo_sp_r;
        htr_cur_pkg::OFS_HI_SP: rdata_nxt = hi_sp_r;
        htr_cur_pkg::OFS_TRIP_SP: rdata_nxt = trip_sp_r;
        htr_cur_pkg::OFS_LIMIT_SP: rdata_nxt = lim_sp_r;
        htr_cur_pkg::OFS_CTRL: rdata_nxt = {30'h0, ctrl_r};
        htr_cur_pkg::OFS_FLAGS: rdata_nxt = {22'h0, flag_r};
        htr_cur_pkg::OFS_IRQ_MASK: rdata_nxt = {22'h0, mask_r};
        htr_cur_pkg::OFS_IRQ_STAT: begin
          rdata_nxt = {22'h0, stat_r};
          rd_clr = '1;
        end
        htr_cur_pkg::OFS_TRIP_CLR: rdata_nxt = {29'h0, trip_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = htr_cur_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (sample_valid) begin
      // Low and high alarms follow the comparison each sample; they never latch.
      flag_nxt[htr_cur_pkg::FLG_LO +: 3] = lo_hit;
      flag_nxt[htr_cur_pkg::FLG_HI +: 3] = hi_hit;
      trip_nxt = trip_nxt | trip_hit;
      trip_cond_nxt = trip_hit;
      lim_nxt = (lim_sp_r[7:0] != htr_cur_pkg::SP_OFF) && ({2'b00, cur_main} > {2'b00, lim_sp_r[7:0]});
    end
    flag_nxt[htr_cur_pkg::FLG_TRIP +: 3] = trip_nxt;
    flag_nxt[htr_cur_pkg::FLG_LIM] = lim_nxt;
  end

  // New raised flags are events; a set in the clearing cycle survives the read.
  assign events = flag_nxt & ~flag_r;

  always_comb begin
    stat_nxt = (stat_r & ~rd_clr) | events;
    irq_nxt = |(stat_nxt & mask_r);
    // Heater opens on any latched trip; the limit gates it off while the
    // last sampled main current (cur_main) stands above the limit setpoint.
    heater_on_nxt = (trip_nxt == 3'b000) && !lim_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_sp_r <= htr_cur_pkg::SP_RESET;
      hi_sp_r <= htr_cur_pkg::SP_RESET;
      trip_sp_r <= htr_cur_pkg::SP_RESET;
      lim_sp_r <= htr_cur_pkg::SP_RESET;
      ctrl_r <= 2'b00;
      stat_r <= '0;
      mask_r <= '0;
      flag_r <= '0;
      trip_r <= 3'b000;
      lim_r <= 1'b0;
      heater_on_r <= 1'b0;
      irq_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
      trip_cond_r <= 3'b000;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      lo_sp_r <= lo_sp_nxt;
      hi_sp_r <= hi_sp_nxt;
      trip_sp_r <= trip_sp_nxt;
      lim_sp_r <= lim_sp_nxt;
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      flag_r <= flag_nxt;
      trip_r <= trip_nxt;
      lim_r <= lim_nxt;
      heater_on_r <= heater_on_nxt;
      irq_r <= irq_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      trip_cond_r <= trip_cond_nxt;
      awready_r <= !aw_got_nxt;
      wready_r <= !w_got_nxt;
      arready_r <= !rvalid_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign arready = arready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign heater_on = heater_on_r;
  assign irq = irq_r;
endmodule

// ===== sim/heater_current_alarm_trip_monitor.sv
`timescale 1ns/1ps
module heater_current_alarm_trip_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic sample_valid,
  input wire logic heater_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take_s;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take_s;
    arvalid && arready;
  endsequence
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer withdrawn");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer withdrawn");
  rd_answer_a: assert property (rd_take_s |=> rvalid)
    else $error("read answer late");
  wr_refuse_a: assert property (wr_take_s ##0 (awaddr > 8'h20)
    |-> ##2 bvalid && bresp == htr_cur_pkg::RESP_SLVERR)
    else $error("unmapped write accepted");
  rd_refuse_a: assert property (rd_take_s ##0 (araddr > 8'h20)
    |=> rresp == htr_cur_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read accepted");
  rd_okay_a: assert property (rd_take_s ##0 (araddr <= 8'h20 && araddr[1:0] == 2'h0)
    |=> rresp == htr_cur_pkg::RESP_OKAY)
    else $error("mapped read refused");
  wr_busy_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  heater_open_a: assert property ($fell(heater_on) |-> $past(sample_valid))
    else $error("heater opened without a sample");
  heater_wake_a: assert property ($rose(aresetn) |=> heater_on)
    else $error("heater not closed after reset");
endmodule

bind heater_current_alarm_trip heater_current_alarm_trip_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .sample_valid(sample_valid), .heater_on(heater_on)
);

// ===== sim/heater_side_model.sv
`timescale 1ns/1ps
module heater_side_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic heater_on,
  input wire logic [23:0] load_cur,
  input wire logic [7:0] load_duty,
  output logic sample_valid,
  output logic [7:0] cur_main,
  output logic [7:0] cur_b,
  output logic [7:0] cur_c,
  output logic [7:0] duty
);
  // An open circuit carries no current; between samples the lines carry
  // inverted data so that a stale value is never mistaken for a sample.
  logic [1:0] tick_r;
  logic [1:0] tick_nxt;
  logic [23:0] meas;
  always_comb begin
    tick_nxt = aresetn ? tick_r + 2'h1 : 2'h0;
  end
  always_ff @(posedge aclk) begin
    tick_r <= tick_nxt;
  end
  assign sample_valid = aresetn && tick_r == 2'h3;
  assign meas = heater_on ? load_cur : 24'h0;
  assign cur_main = sample_valid ? meas[7:0] : ~meas[7:0];
  assign cur_b = sample_valid ? meas[15:8] : ~meas[15:8];
  assign cur_c = sample_valid ? meas[23:16] : ~meas[23:16];
  assign duty = sample_valid ? load_duty : ~load_duty;
endmodule

// ===== sim/test_heater_current_alarm_trip.sv
`timescale 1ns/1ps
module test_heater_current_alarm_trip;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sample_valid, heater_on, irq;
  logic [7:0] awaddr, araddr, cur_main, cur_b, cur_c, duty, load_duty;
  logic [31:0] wdata, rdata, e;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [23:0] load_cur;
  logic [7:0] c[3];
  logic [33:0] exp_q[$];
  int n_mismatch, cmp_count, seed, i, k, sum, ns;

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  heater_current_alarm_trip dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_valid(sample_valid), .cur_main(cur_main), .cur_b(cur_b), .cur_c(cur_c),
    .duty(duty), .heater_on(heater_on), .irq(irq)
  );
  heater_side_model far_u (
    .aclk(aclk), .aresetn(aresetn), .heater_on(heater_on), .load_cur(load_cur),
    .load_duty(load_duty), .sample_valid(sample_valid), .cur_main(cur_main),
    .cur_b(cur_b), .cur_c(cur_c), .duty(duty)
  );

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [33:0] okw(input logic [31:0] v);
    return {htr_cur_pkg::RESP_OKAY, v};
  endfunction

  function automatic logic [23:0] put(input int p, input logic [7:0] v);
    return (24'h1E_1E1E & ~(24'hFF << 8 * p)) | (24'(v) << 8 * p);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = htr_cur_pkg::RESP_OKAY);
    int t;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'h3;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      // A late bready makes the slave hold its answer for a cycle.
      if (t == 2) bready <= 1'h1;
    end
    bready <= 1'h0;
    if (t == 40) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] want);
    int t;
    exp_q.push_back(want);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    for (t = 0; t < 40; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      if (t == 1) rready <= 1'h1;
    end
    rready <= 1'h0;
    if (t == 40) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  always @(posedge aclk) begin
    if (bvalid && bready) chk("write answer", {bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) chk("read answer", {rresp, rdata}, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h9444;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    load_cur = 24'h1E_1E1E;
    load_duty = 8'hFF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 9; i++) rd(8'(4 * i), okw(32'h0));
    chk("heater", 34'(heater_on), 34'h1);
    wr(8'h40, 32'h1, htr_cur_pkg::RESP_SLVERR);
    rd(8'h40, {htr_cur_pkg::RESP_SLVERR, 32'h0});
    wr(htr_cur_pkg::OFS_HI_SP, 32'h0028_FF28);
    rd(htr_cur_pkg::OFS_HI_SP, okw(32'h0028_3C28));
    wr(htr_cur_pkg::OFS_CTRL, 32'h2);
    wr(htr_cur_pkg::OFS_HI_SP, 32'h0028_FF28);
    rd(htr_cur_pkg::OFS_HI_SP, okw(32'h0028_C828));
    wr(htr_cur_pkg::OFS_CTRL, 32'h0);
    wr(htr_cur_pkg::OFS_HI_SP, 32'h0028_2828);
    wr(htr_cur_pkg::OFS_LO_SP, 32'h0014_1414);
    wr(htr_cur_pkg::OFS_IRQ_MASK, 32'h8);
    load_cur <= put(0, 8'h2D);
    repeat (10) @(posedge aclk);
    chk("irq", 34'(irq), 34'h1);
    wr(htr_cur_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq", 34'(irq), 34'h0);
    wr(htr_cur_pkg::OFS_IRQ_MASK, 32'h8);
    repeat (3) @(posedge aclk);
    chk("irq", 34'(irq), 34'h1);
    rd(htr_cur_pkg::OFS_IRQ_STAT, okw(32'h8));
    repeat (3) @(posedge aclk);
    chk("irq", 34'(irq), 34'h0);
    // Currents straddle both setpoints so every boundary is hit.
    for (k = 0; k < 12; k++) begin
      for (i = 0; i < 3; i++) c[i] = 8'(17 + $unsigned($random(seed)) % 26);
      load_cur <= {c[2], c[1], c[0]};
      repeat (10) @(posedge aclk);
      e = 32'h0;
      for (i = 0; i < 3; i++) begin
        e[htr_cur_pkg::FLG_LO + i] = c[i] <= 8'h14;
        e[htr_cur_pkg::FLG_HI + i] = c[i] >= 8'h28;
      end
      rd(htr_cur_pkg::OFS_FLAGS, okw(e));
    end
    // Half duty: raw 15 would be low and 21 scales past the high setpoint.
    wr(htr_cur_pkg::OFS_CTRL, 32'h1);
    load_duty <= 8'h80;
    load_cur <= 24'h15_150F;
    repeat (10) @(posedge aclk);
    rd(htr_cur_pkg::OFS_FLAGS, okw(32'h0));
    wr(htr_cur_pkg::OFS_CTRL, 32'h0);
    load_duty <= 8'hFF;
    for (i = 0; i < 3; i++) begin
      load_cur <= 24'h1E_1E1E;
      wr(htr_cur_pkg::OFS_TRIP_SP, 32'h32 << 8 * i);
      load_cur <= put(i, 8'h37);
      repeat (10) @(posedge aclk);
      chk("heater", 34'(heater_on), 34'h0);
      rd(htr_cur_pkg::OFS_FLAGS, okw(32'h7 | 32'h1 << htr_cur_pkg::FLG_TRIP + i));
      load_cur <= 24'h1E_1E1E;
      wr(htr_cur_pkg::OFS_TRIP_CLR, 32'h1 << (i + 1) % 3);
      repeat (10) @(posedge aclk);
      chk("heater", 34'(heater_on), 34'h0);
      rd(htr_cur_pkg::OFS_TRIP_CLR, okw(32'h1 << i));
      wr(htr_cur_pkg::OFS_TRIP_CLR, 32'h1 << i);
      repeat (3) @(posedge aclk);
      chk("heater", 34'(heater_on), 34'h1);
    end
    wr(htr_cur_pkg::OFS_TRIP_SP, 32'h0);
    wr(htr_cur_pkg::OFS_LIMIT_SP, 32'h14);
    load_cur <= put(0, 8'h28);
    repeat (20) @(posedge aclk);
    {sum, ns} = 64'h0;
    for (k = 0; k < 80; k++) begin
      @(posedge aclk);
      if (sample_valid) begin
        sum += cur_main;
        ns++;
      end
    end
    // One sample of slack covers a window edge falling mid-cycle.
    chk("average current", 34'(sum <= 20 * ns + 40 && ns > 0), 34'h1);
    print_verdict();
  end
endmodule
